/* File: core/motion_unit_defs.svh */
`ifndef MOTION_UNIT_DEFS_SVH
`define MOTION_UNIT_DEFS_SVH
// ==========================================================
// register offsets
`define OFS_DECEL_TIME      16'h0022
`define OFS_START_CTRL      16'h0027
`define OFS_STOP_CTRL       16'h0028
`define OFS_HOMING_TRIG     16'h0030
`define OFS_TERM_FUNC_BASE  16'h0043
`define OFS_MULTI_POS_CMD   16'h0070
// ==========================================================
// field positions and writable masks
`define START_TYPE_LSB      0
`define START_ABS_BIT       2
`define START_MASK          16'h0007
`define STOP_MASK           16'h0001
`define HOMING_MASK         16'h0001
`define MP_TRIG_BIT         0
`define MP_SEC_LSB          4
`define MP_MASK             16'h00f1
// ==========================================================
// motion type codes
`define TYPE_POSITION       2'h1
`define TYPE_SPEED          2'h2
// ==========================================================
// input terminal function codes
`define FUNC_NONE           8'h00
`define FUNC_ORIGIN         8'h01
`define FUNC_LIMIT_FWD      8'h02
`define FUNC_LIMIT_REV      8'h03
// ==========================================================
// fault codes and subcodes
`define CODE_OVERCURRENT    8'h01
`define SUB_OVERCURRENT     8'h10
`define CODE_OVERVOLTAGE    8'h02
`define SUB_OVERVOLTAGE     8'h20
`define CODE_UNDERVOLTAGE   8'h03
`define SUB_UNDERVOLTAGE    8'h30
`define CODE_STORAGE        8'h04
`define SUB_STORAGE_RD      8'h41
`define SUB_STORAGE_WR      8'h42
`define CODE_POS_DEV        8'h05
`define SUB_POS_DEV         8'h50
// ==========================================================
// reset values and timing
`define RESET_WORD          16'h0000
`define CLK_HZ              25000000
`define INPUT_HOLD_MS       10
`define LAMP_HALF_MS        250
`define LAMP_PAUSE_HALVES   4
`endif

/* File: core/motion_unit_pkg.sv */
`default_nettype none
package motion_unit_pkg;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_RUN_POS,
		ST_RUN_SPD,
		ST_DECEL,
		ST_HOME_FAST,
		ST_HOME_STOP1,
		ST_HOME_REV,
		ST_HOME_STOP2,
		ST_HOME_SLOW
	} motion_state_t;

	typedef struct packed {
		logic pos_start;
		logic spd_start;
		logic absolute;
	} motion_cmd_t;

	typedef struct packed {
		logic [7:0] code;
		logic [7:0] sub;
	} fault_rec_t;
endpackage : motion_unit_pkg
`default_nettype wire

/* File: core/stepper_motion_command_unit.sv */
// Notes on behaviour
// RQ1 - start bits 1:0: 1 position, 2 speed
// RQ2 - bit 2 absolute, only for position moves
// RQ3 - start write itself launches the move
// RQ4 - stop write: bit0 0 ramp, 1 emergency
// RQ5 - controlled stop ramps speed over deceleration time
// RQ6 - emergency stop cuts pulses with no ramp
// RQ7 - deceleration time captured when motion starts
// RQ8 - homing register 1 starts homing, 0 ignored
// RQ9 - multi-position bit0 triggers next section
// RQ10 - section field: 0 default, else chosen section
// RQ11 - master holds input levels over 10 ms
// RQ12 - inputs ignored until function assigned
// RQ13 - differential inputs: pulse source or plain inputs
// RQ14 - overcurrent: code 1/0x10, one flash, latched
// RQ15 - overvoltage: code 2/0x20, two flashes, self-clears
// RQ16 - undervoltage: code 3/0x30, three flashes, self-clears
// RQ17 - storage: code 4, 0x41/0x42, four flashes, resettable
// RQ18 - position deviation: code 5/0x50, latched
// RQ19 - every fault emits a storage record; code writes one per cycle, holding the highest-priority active fault
// RQ20 - homing: fast, stop, reverse, stop, slow search
// RQ21 - limit during homing reverses travel
// RQ22 - section priority: bus, external, jump parameter
// RQ23 - reserved command bits ignored, read zero
`include "motion_unit_defs.svh"
`default_nettype none
module stepper_motion_command_unit
	import motion_unit_pkg::*;
#(
	parameter int MS_CYC = `CLK_HZ / 1000
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	input  wire logic [15:0] run_speed,
	input  wire logic        motion_done,
	input  wire logic [4:0]  general_inputs,
	input  wire logic [1:0]  diff_in,
	input  wire logic        diff_pulse_mode,
	input  wire logic        mp_ext_valid,
	input  wire logic [4:0]  mp_ext_section,
	input  wire logic [4:0]  mp_jump_section,
	input  wire logic        overcurrent_fault,
	input  wire logic        overvoltage_fault,
	input  wire logic        undervoltage_fault,
	input  wire logic        storage_rd_err,
	input  wire logic        storage_wr_err,
	input  wire logic        position_deviation_fault,
	input  wire logic        fault_reset,
	output motion_cmd_t      motion_cmd,
	output logic             pulse_enable,
	output logic      [15:0] speed_out,
	output logic             home_dir,
	output logic             home_slow,
	output logic             homing_busy,
	output logic             mp_trigger,
	output logic      [4:0]  mp_section,
	output logic      [4:0]  in_qual,
	output logic      [1:0]  diff_pulse,
	output logic      [1:0]  diff_gp,
	output logic             lamp,
	output logic             drive_locked,
	output fault_rec_t       fault_now,
	output logic             rec_wr,
	output fault_rec_t       rec
);
	localparam int FILT_CYC = `INPUT_HOLD_MS * MS_CYC;
	localparam int HALF_CYC = `LAMP_HALF_MS * MS_CYC;

	// ==========================================================
	// register file
	logic [15:0]   decel_r, start_r, stop_r, home_r, mp_r;
	logic [7:0]    func_r [5];
	logic [15:0]   decel_cap_r;
	motion_state_t st_r, st_nxt;

	wire wr_start = reg_wr && reg_addr == `OFS_START_CTRL;
	wire wr_stop  = reg_wr && reg_addr == `OFS_STOP_CTRL;
	wire wr_home  = reg_wr && reg_addr == `OFS_HOMING_TRIG;
	wire wr_mp    = reg_wr && reg_addr == `OFS_MULTI_POS_CMD;
	wire [1:0] start_type = reg_wdata[`START_TYPE_LSB +: 2];
	wire estop_req = wr_stop && reg_wdata[0];
	wire nstop_req = wr_stop && !reg_wdata[0];
	wire [15:0] tf_ofs = reg_addr - `OFS_TERM_FUNC_BASE;
	wire tf_hit = reg_addr >= `OFS_TERM_FUNC_BASE && tf_ofs < 16'h0005;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			decel_r <= `RESET_WORD;
			start_r <= `RESET_WORD;
			stop_r  <= `RESET_WORD;
			home_r  <= `RESET_WORD;
			mp_r    <= `RESET_WORD;
		end else begin
			if (reg_wr && reg_addr == `OFS_DECEL_TIME)
				decel_r <= reg_wdata;
			// RQ23 reserved bits dropped
			if (wr_start)
				start_r <= reg_wdata & `START_MASK;
			if (wr_stop)
				stop_r <= reg_wdata & `STOP_MASK;
			if (wr_home)
				home_r <= reg_wdata & `HOMING_MASK;
			if (wr_mp)
				mp_r <= reg_wdata & `MP_MASK;
		end
	end

	// RQ12 terminal functions start unassigned
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_term
			logic [19:0] filt_cnt_r;
			logic        stable_r, last_r;
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n)
					func_r[g] <= `FUNC_NONE;
				else if (reg_wr && tf_hit && tf_ofs[2:0] == 3'(g))
					func_r[g] <= reg_wdata[7:0];
			end
			// level must persist the full hold time before it is believed
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					filt_cnt_r <= 20'h00000;
					stable_r   <= 1'b0;
					last_r     <= 1'b0;
				end else begin
					last_r <= general_inputs[g];
					if (general_inputs[g] != last_r || general_inputs[g] == stable_r)
						filt_cnt_r <= 20'h00000;
					else if (filt_cnt_r == 20'(FILT_CYC - 1)) begin
						stable_r   <= general_inputs[g];
						filt_cnt_r <= 20'h00000;
					end else
						filt_cnt_r <= filt_cnt_r + 20'h00001;
				end
			end
			// RQ12 unassigned input reads inactive
			assign in_qual[g] = stable_r && func_r[g] != `FUNC_NONE;
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 16'h0000;
		else if (reg_rd) begin
			unique case (1'b1)
				reg_addr == `OFS_DECEL_TIME:    reg_rdata <= decel_r;
				reg_addr == `OFS_START_CTRL:    reg_rdata <= start_r;
				reg_addr == `OFS_STOP_CTRL:     reg_rdata <= stop_r;
				reg_addr == `OFS_HOMING_TRIG:   reg_rdata <= home_r;
				reg_addr == `OFS_MULTI_POS_CMD: reg_rdata <= mp_r;
				tf_hit:                         reg_rdata <= {8'h00, func_r[tf_ofs[2:0]]};
				default:                        reg_rdata <= 16'h0000;
			endcase
		end
	end

	// ==========================================================
	// differential inputs
	// RQ13 route to pulse path or general use
	assign diff_pulse = diff_pulse_mode ? diff_in : 2'h0;
	assign diff_gp    = diff_pulse_mode ? 2'h0 : diff_in;

	// ==========================================================
	// fault handling
	logic oc_r, pd_r, st_err_r, st_wr_r;
	logic [4:0] flt_prev_r;
	// RQ15 RQ16 voltage faults follow the supply level
	wire [4:0] flt_now = {pd_r, st_err_r, undervoltage_fault, overvoltage_fault, oc_r};
	// RQ14 RQ18 latched until power cycle; RQ17 set wins over reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			oc_r       <= 1'b0;
			pd_r       <= 1'b0;
			st_err_r   <= 1'b0;
			st_wr_r    <= 1'b0;
			flt_prev_r <= 5'h00;
		end else begin
			oc_r <= oc_r | overcurrent_fault;
			pd_r <= pd_r | position_deviation_fault;
			if (storage_rd_err || storage_wr_err) begin
				st_err_r <= 1'b1;
				st_wr_r  <= storage_wr_err && !storage_rd_err;
			end else if (fault_reset)
				st_err_r <= 1'b0;
			flt_prev_r <= flt_now;
		end
	end

	wire [4:0] flt_rise = flt_now & ~flt_prev_r;
	wire [7:0] st_sub = st_wr_r ? `SUB_STORAGE_WR : `SUB_STORAGE_RD;
	// storage fault alone does not lock the drive
	assign drive_locked = oc_r | overvoltage_fault | undervoltage_fault | pd_r;

	always_comb begin
		fault_now = '{code: 8'h00, sub: 8'h00};
		unique casez (flt_now)
			5'b????1: fault_now = '{code: `CODE_OVERCURRENT,  sub: `SUB_OVERCURRENT};
			5'b???10: fault_now = '{code: `CODE_OVERVOLTAGE,  sub: `SUB_OVERVOLTAGE};
			5'b??100: fault_now = '{code: `CODE_UNDERVOLTAGE, sub: `SUB_UNDERVOLTAGE};
			5'b?1000: fault_now = '{code: `CODE_STORAGE,      sub: st_sub};
			5'b10000: fault_now = '{code: `CODE_POS_DEV,      sub: `SUB_POS_DEV};
			5'b00000: fault_now = '{code: 8'h00, sub: 8'h00};
		endcase
	end

	// RQ19 one record per cycle in which any fault rises, holding the highest-priority active fault
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rec_wr <= 1'b0;
			rec    <= '{code: 8'h00, sub: 8'h00};
		end else begin
			rec_wr <= |flt_rise;
			if (|flt_rise)
				rec <= fault_now;
		end
	end

	// RQ14 RQ15 RQ16 RQ17 RQ18 lamp flashes code times, then pauses
	logic [23:0] half_cnt_r;
	logic [4:0]  phase_r;
	wire  [4:0]  flashes2 = 5'({fault_now.code[3:0], 1'b0});
	wire         half_end = half_cnt_r == 24'(HALF_CYC - 1);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			half_cnt_r <= 24'h000000;
			phase_r    <= 5'h00;
		end else if (fault_now.code == 8'h00) begin
			half_cnt_r <= 24'h000000;
			phase_r    <= 5'h00;
		end else begin
			half_cnt_r <= half_end ? 24'h000000 : half_cnt_r + 24'h000001;
			if (half_end)
				phase_r <= phase_r >= flashes2 + 5'(`LAMP_PAUSE_HALVES - 1) ?
					5'h00 : phase_r + 5'h01;
		end
	end
	assign lamp = fault_now.code != 8'h00 && phase_r < flashes2 && !phase_r[0];

	// ==========================================================
	// motion sequencer
	logic [15:0] spd_r;
	logic [15:0] speed0_r;
	logic [39:0] err_r;
	logic        dir_r, abs_r;
	wire  [39:0] ramp_total = 40'(decel_cap_r) * 40'(MS_CYC);
	wire         stopping = st_r == ST_DECEL || st_r == ST_HOME_STOP1 ||
		st_r == ST_HOME_STOP2;
	wire         homing = st_r inside {ST_HOME_FAST, ST_HOME_STOP1, ST_HOME_REV,
		ST_HOME_STOP2, ST_HOME_SLOW};
	logic [4:0]  org_lvl, lim_lvl;
	logic        org_prev_r, lim_prev_r;
	generate
		for (g = 0; g < 5; g++) begin : g_role
			assign org_lvl[g] = in_qual[g] && func_r[g] == `FUNC_ORIGIN;
			assign lim_lvl[g] = in_qual[g] && (func_r[g] == `FUNC_LIMIT_FWD ||
				func_r[g] == `FUNC_LIMIT_REV);
		end
	endgenerate
	wire org_rise = |org_lvl && !org_prev_r;
	wire org_fall = !(|org_lvl) && org_prev_r;
	wire lim_rise = |lim_lvl && !lim_prev_r;
	wire start_ok = wr_start && !drive_locked && !homing;

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_IDLE: begin
				// RQ3 the write is the trigger
				if (start_ok && start_type == `TYPE_POSITION)
					st_nxt = ST_RUN_POS;
				else if (start_ok && start_type == `TYPE_SPEED)
					st_nxt = ST_RUN_SPD;
				// RQ8 only bit 0 set starts homing, upper bits ignored
				else if (wr_home && reg_wdata[0] && !drive_locked)
					st_nxt = ST_HOME_FAST;
			end
			ST_RUN_POS:    if (motion_done) st_nxt = ST_IDLE;
			ST_RUN_SPD:    st_nxt = ST_RUN_SPD;
			ST_DECEL:      if (spd_r == 16'h0000) st_nxt = ST_IDLE;
			// RQ20 homing sequence
			ST_HOME_FAST:  if (org_rise) st_nxt = ST_HOME_STOP1;
			ST_HOME_STOP1: if (spd_r == 16'h0000) st_nxt = ST_HOME_REV;
			ST_HOME_REV:   if (org_fall) st_nxt = ST_HOME_STOP2;
			ST_HOME_STOP2: if (spd_r == 16'h0000) st_nxt = ST_HOME_SLOW;
			ST_HOME_SLOW:  if (org_rise) st_nxt = ST_IDLE;
		endcase
		// RQ4 RQ5 controlled stop ramps from a position or speed run
		if (nstop_req && (st_r == ST_RUN_POS || st_r == ST_RUN_SPD))
			st_nxt = ST_DECEL;
		// RQ6 emergency stop or lock drops straight to idle
		if (estop_req || drive_locked)
			st_nxt = ST_IDLE;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r        <= ST_IDLE;
			decel_cap_r <= 16'h0000;
			abs_r       <= 1'b0;
			dir_r       <= 1'b0;
			org_prev_r  <= 1'b0;
			lim_prev_r  <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			org_prev_r <= |org_lvl;
			lim_prev_r <= |lim_lvl;
			// RQ7 deceleration time frozen at motion start
			if (st_r == ST_IDLE && st_nxt != ST_IDLE)
				decel_cap_r <= decel_r;
			// RQ2 absolute flag only meaningful for position moves
			if (st_r == ST_IDLE && st_nxt == ST_RUN_POS)
				abs_r <= reg_wdata[`START_ABS_BIT];
			if (st_r == ST_IDLE && st_nxt == ST_HOME_FAST)
				dir_r <= 1'b0;
			// RQ20 reverse after first stop, reverse again for slow search
			else if (st_r == ST_HOME_STOP1 && st_nxt == ST_HOME_REV)
				dir_r <= ~dir_r;
			else if (st_r == ST_HOME_STOP2 && st_nxt == ST_HOME_SLOW)
				dir_r <= ~dir_r;
			// RQ21 limit hit turns homing around
			else if (homing && lim_rise)
				dir_r <= ~dir_r;
		end
	end

	// RQ5 speed falls by one step whenever the error term passes the ramp length
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			spd_r    <= 16'h0000;
			speed0_r <= 16'h0000;
			err_r    <= 40'h0;
		end else if (st_nxt == ST_IDLE) begin
			spd_r <= 16'h0000;
			err_r <= 40'h0;
		end else if (stopping) begin
			if (ramp_total == 40'h0)
				spd_r <= 16'h0000;
			else if (err_r + 40'(speed0_r) >= ramp_total) begin
				err_r <= err_r + 40'(speed0_r) - ramp_total;
				spd_r <= spd_r - 16'h0001;
			end else
				err_r <= err_r + 40'(speed0_r);
		end else begin
			spd_r    <= run_speed;
			speed0_r <= run_speed;
			err_r    <= 40'h0;
		end
	end

	// RQ1 RQ2 one-cycle launch strobes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			motion_cmd <= '{pos_start: 1'b0, spd_start: 1'b0, absolute: 1'b0};
		else begin
			motion_cmd.pos_start <= st_r == ST_IDLE && st_nxt == ST_RUN_POS;
			motion_cmd.spd_start <= st_r == ST_IDLE && st_nxt == ST_RUN_SPD;
			motion_cmd.absolute  <= st_r == ST_IDLE && st_nxt == ST_RUN_POS &&
				reg_wdata[`START_ABS_BIT];
		end
	end

	// RQ6 pulses stop the cycle after an emergency stop
	assign pulse_enable = st_r != ST_IDLE && spd_r != 16'h0000;
	assign speed_out    = spd_r;
	assign home_dir     = dir_r;
	assign home_slow    = st_r == ST_HOME_SLOW;
	assign homing_busy  = homing;

	// ==========================================================
	// multi-position trigger
	wire [4:0] bus_sec = {1'b0, reg_wdata[`MP_SEC_LSB +: 4]};
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mp_trigger <= 1'b0;
			mp_section <= 5'h00;
		end else begin
			// RQ9 bit0 set fires, clear is no request
			mp_trigger <= wr_mp && reg_wdata[`MP_TRIG_BIT] && !drive_locked;
			// RQ10 RQ22 bus choice over external over jump parameter
			if (wr_mp && reg_wdata[`MP_TRIG_BIT])
				mp_section <= bus_sec != 5'h00 ? bus_sec :
					mp_ext_valid ? mp_ext_section : mp_jump_section;
		end
	end

	// ==========================================================
	// checks
	sequence s_pos_write;
		wr_start && start_type == `TYPE_POSITION && st_r == ST_IDLE && !drive_locked;
	endsequence
	sequence s_launch_pos;
		st_r == ST_RUN_POS && motion_cmd.pos_start;
	endsequence

	property p_pos_start;
		@(posedge sys_clk) disable iff (!rst_n)
		(s_pos_write and !estop_req) |=> s_launch_pos;
	endproperty
	a_pos_start: assert property (p_pos_start) else $error("position start lost"); // RQ1

	property p_abs_flag;
		@(posedge sys_clk) disable iff (!rst_n)
		s_pos_write |=> motion_cmd.absolute == $past(reg_wdata[`START_ABS_BIT]);
	endproperty
	a_abs_flag: assert property (p_abs_flag) else $error("absolute flag wrong"); // RQ2

	property p_spd_start;
		@(posedge sys_clk) disable iff (!rst_n)
		wr_start && start_type == `TYPE_SPEED && st_r == ST_IDLE && !drive_locked
			&& !estop_req |=> st_r == ST_RUN_SPD && motion_cmd.spd_start
			##1 !motion_cmd.spd_start;
	endproperty
	a_spd_start: assert property (p_spd_start) else $error("speed start wrong"); // RQ3

	property p_estop;
		@(posedge sys_clk) disable iff (!rst_n)
		estop_req |=> !pulse_enable && speed_out == 16'h0000;
	endproperty
	a_estop: assert property (p_estop) else $error("emergency stop ramped"); // RQ6

	property p_decel_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		st_r == ST_DECEL && $past(st_r) == ST_DECEL |-> $stable(decel_cap_r);
	endproperty
	a_decel_hold: assert property (p_decel_hold) else $error("decel time changed"); // RQ7

	property p_ramp;
		@(posedge sys_clk) disable iff (!rst_n)
		st_r == ST_DECEL && spd_r != 16'h0000 && !estop_req && !drive_locked
			|=> spd_r == $past(spd_r) || spd_r == $past(spd_r) - 16'h0001;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp not monotonic"); // RQ5

	property p_home;
		@(posedge sys_clk) disable iff (!rst_n)
		wr_home && !reg_wdata[0] && st_r == ST_IDLE |=> !homing_busy;
	endproperty
	a_home: assert property (p_home) else $error("homing on zero write"); // RQ8

	property p_mp_sel;
		@(posedge sys_clk) disable iff (!rst_n)
		wr_mp && reg_wdata[0] && bus_sec != 5'h00 && !drive_locked
			|=> mp_trigger && mp_section == $past(bus_sec);
	endproperty
	a_mp_sel: assert property (p_mp_sel) else $error("bus section ignored"); // RQ22

	property p_oc_lock;
		@(posedge sys_clk) disable iff (!rst_n)
		overcurrent_fault |=> drive_locked [*8];
	endproperty
	a_oc_lock: assert property (p_oc_lock) else $error("overcurrent not latched"); // RQ14

	property p_ov_code;
		@(posedge sys_clk) disable iff (!rst_n)
		overvoltage_fault && !oc_r && !overcurrent_fault |-> fault_now.code == `CODE_OVERVOLTAGE
			&& fault_now.sub == `SUB_OVERVOLTAGE;
	endproperty
	a_ov_code: assert property (p_ov_code) else $error("overvoltage code wrong"); // RQ15

	property p_unassigned;
		@(posedge sys_clk) disable iff (!rst_n)
		func_r[0] == `FUNC_NONE |-> !in_qual[0];
	endproperty
	a_unassigned: assert property (p_unassigned) else $error("unassigned input live"); // RQ12

	property p_reserved;
		@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && reg_addr == `OFS_START_CTRL |=> reg_rdata[15:3] == 13'h0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits read back"); // RQ23

	property p_record;
		@(posedge sys_clk) disable iff (!rst_n)
		undervoltage_fault && !flt_prev_r[2] |=> rec_wr;
	endproperty
	a_record: assert property (p_record) else $error("fault not recorded"); // RQ19
endmodule : stepper_motion_command_unit
`default_nettype wire

/* File: dv/reg_master.sv */
`default_nettype none
// ==========================================================
// register bus master standing in for the host
module reg_master (
	input  wire logic        sys_clk,
	input  wire logic [15:0] reg_rdata,
	output var logic         reg_wr,
	output var logic         reg_rd,
	output var logic  [15:0] reg_addr,
	output var logic  [15:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 16'h0000;
		reg_wdata = 16'h0000;
	end

	// ==========================================================
	// one write, one command
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
		// idle bus carries no stale word
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask : rd
endmodule : reg_master
`default_nettype wire

/* File: dv/stepper_motion_command_unit_bench.sv */
`default_nettype none
module stepper_motion_command_unit_bench;
	import motion_unit_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// shortened millisecond so lamp and filter counts stay small
	localparam int MS   = 4;
	localparam int HALF = 250 * MS;
	logic        sys_clk = 1'b0;
	logic        rst_n   = 1'b0;
	logic        reg_wr, reg_rd, motion_done, diff_pulse_mode, mp_ext_valid;
	logic        storage_wr_err, fault_reset, pulse_enable, home_dir, home_slow;
	logic        homing_busy, mp_trigger, lamp, drive_locked, rec_wr, p;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, run_speed, speed_out, d;
	logic [4:0]  general_inputs, mp_ext_section, mp_jump_section, mp_section, in_qual, flt;
	logic [1:0]  diff_in, diff_pulse, diff_gp;
	motion_cmd_t motion_cmd;
	fault_rec_t  fault_now, rec;
	int          bad_count = 0;
	int          total_checks = 0;
	int          i, k, c;

	initial begin
		forever #20 sys_clk = ~sys_clk;
	end

	reg_master host (.sys_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

	stepper_motion_command_unit #(.MS_CYC(MS)) dut (
		.sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.run_speed, .motion_done, .general_inputs, .diff_in, .diff_pulse_mode,
		.mp_ext_valid, .mp_ext_section, .mp_jump_section,
		.overcurrent_fault(flt[0]), .overvoltage_fault(flt[1]),
		.undervoltage_fault(flt[2]), .storage_rd_err(flt[3]),
		.storage_wr_err, .position_deviation_fault(flt[4]), .fault_reset,
		.motion_cmd, .pulse_enable, .speed_out, .home_dir, .home_slow,
		.homing_busy, .mp_trigger, .mp_section, .in_qual, .diff_pulse, .diff_gp,
		.lamp, .drive_locked, .fault_now, .rec_wr, .rec
	);

	// ==========================================================
	// shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test;
		if (bad_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	task automatic do_reset;
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
	endtask : do_reset

	task automatic wr1(input logic [15:0] a, input logic [15:0] v);
		host.wr(a, v);
		@(negedge sys_clk);
	endtask : wr1

	task automatic bail(input logic ok);
		if (!ok) begin
			bad_count++;
			stop_test();
		end
	endtask : bail

	// ==========================================================
	// main sequence
	initial begin
		{motion_done, storage_wr_err, fault_reset, flt} = '0;
		{diff_pulse_mode, mp_ext_valid} = 2'h3;
		run_speed = 16'h0003;
		general_inputs = 5'h01;
		diff_in = 2'h2;
		mp_ext_section = 5'h07;
		mp_jump_section = 5'h09;
		do_reset();
		host.rd(16'h0027, d);
		chk(d, 16'h0000);
		wr1(16'h0027, 16'hfffd);
		chk(motion_cmd, 3'h5);
		chk(speed_out, 16'h0003);
		host.rd(16'h0027, d);
		chk(d, 16'h0005);
		wr1(16'h0028, 16'h0001);
		chk(pulse_enable, 1'b0);
		chk(speed_out, 16'h0000);
		wr1(16'h0027, 16'h0003);
		chk(motion_cmd, 3'h0);
		host.wr(16'h0022, 16'h0002);
		wr1(16'h0027, 16'h0006);
		chk(motion_cmd, 3'h2);
		host.wr(16'h0022, 16'h0000);
		wr1(16'h0027, 16'h0001);
		chk(motion_cmd, 3'h0);
		wr1(16'h0028, 16'hfffe);
		chk(pulse_enable, 1'b1);
		for (i = 0; i < 400 && pulse_enable !== 1'b0; i++) @(negedge sys_clk);
		bail(i < 400);
		// captured 2 ms at 4 cycles per ms, not the later zero
		chk(i, 16'h0008);
		wr1(16'h0030, 16'h0000);
		chk(homing_busy, 1'b0);
		wr1(16'h0030, 16'h0001);
		chk(homing_busy, 1'b1);
		wr1(16'h0028, 16'h0001);
		wr1(16'h0070, 16'h0050);
		chk(mp_trigger, 1'b0);
		wr1(16'h0070, 16'h0051);
		chk(mp_trigger, 1'b1);
		chk(mp_section, 5'h05);
		wr1(16'h0070, 16'h0001);
		chk(mp_section, 5'h07);
		@(posedge sys_clk);
		mp_ext_valid <= 1'b0;
		wr1(16'h0070, 16'h0001);
		chk(mp_section, 5'h09);
		chk(in_qual, 5'h00);
		wr1(16'h0043, 16'h0001);
		chk(in_qual, 5'h01);
		@(posedge sys_clk);
		general_inputs <= 5'h00;
		repeat (20) @(negedge sys_clk);
		chk(in_qual, 5'h01);
		repeat (40) @(negedge sys_clk);
		chk(in_qual, 5'h00);
		chk(diff_pulse, 2'h2);
		@(posedge sys_clk);
		diff_pulse_mode <= 1'b0;
		@(negedge sys_clk);
		chk(diff_gp, 2'h2);
		// homing with a limit hit on the way out
		wr1(16'h0044, 16'h0002);
		wr1(16'h0030, 16'h0001);
		for (k = 1; k <= 4; k++) begin
			@(posedge sys_clk);
			general_inputs <= k[0] ? 5'h02 : 5'h03;
			repeat (60) @(negedge sys_clk);
			d = 16'h0715 >> (4 * k - 4);
			chk({home_dir & homing_busy, home_slow, homing_busy}, d & 16'h0007);
		end
		// each fault class in turn; fault reset clears only the storage fault
		for (k = 1; k <= 5; k++) begin
			do_reset();
			@(posedge sys_clk);
			flt <= 5'(1 << (k - 1));
			for (i = 0; i < 6 && rec_wr !== 1'b1; i++) @(negedge sys_clk);
			bail(i < 6);
			d = {8'(k), (k == 4) ? 8'h41 : 8'(k * 16)};
			chk(rec, d);
			chk(fault_now, d);
			chk(drive_locked, k != 4);
			repeat (20) @(negedge sys_clk);
			c = 0;
			p = lamp;
			repeat ((2 * k + 4) * HALF) begin
				@(negedge sys_clk);
				c += (lamp === 1'b1 && p === 1'b0);
				p = lamp;
			end
			chk(c, k);
			@(posedge sys_clk);
			flt <= 5'h00;
			fault_reset <= (k == 4);
			@(posedge sys_clk);
			fault_reset <= 1'b0;
			repeat (2) @(negedge sys_clk);
			chk(drive_locked, k == 1 || k == 5);
			if (k != 1 && k != 5) chk(fault_now, 16'h0000);
		end
		do_reset();
		@(posedge sys_clk);
		storage_wr_err <= 1'b1;
		for (i = 0; i < 6 && rec_wr !== 1'b1; i++) @(negedge sys_clk);
		bail(i < 6);
		chk(rec, 16'h0442);
		stop_test();
	end
endmodule : stepper_motion_command_unit_bench
`default_nettype wire
